// file: logic/edc_regs.vh
// Constants for the EXTENDED_DATA_OUT_PAGE page DRAM controller
`ifndef EDC_REGS_VH
`define EDC_REGS_VH
`define EDC_CLK_NS          100
`define EDC_PWRUP_US        200
`define EDC_PWRUP_CYC       ((`EDC_PWRUP_US * 1000) / `EDC_CLK_NS)
`define EDC_REF_MS          16
`define EDC_REF_ROWS        1024
`define EDC_REF_PERIOD_CYC  ((`EDC_REF_MS * 1000000) / `EDC_CLK_NS)
`define EDC_REF_INT_CYC     (`EDC_REF_PERIOD_CYC / `EDC_REF_ROWS)
`define EDC_WAKE_CYCLES     8
`define EDC_RAS_MIN_NS      60
`define EDC_RAS_CYC         ((`EDC_RAS_MIN_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_RP_MIN_NS       40
`define EDC_RP_CYC          ((`EDC_RP_MIN_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_ADDR_W          20
`define EDC_HALF_W          10
`define EDC_DATA_W          4
`endif

// file: logic/edc_timer.v
// Down-counter used for the controller's waits
`timescale 1ns/1ps
`default_nettype none
module edc_timer (
    input  wire        ref_clk_i,
    input  wire        rst_n_i,
    input  wire        load_i,
    input  wire [18:0] value_i,
    output reg         done_o
);
    reg [18:0] count;
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count  <= 19'h00000;
            done_o <= 1'b0;
        end else if (load_i) begin
            count  <= value_i;
            done_o <= (value_i == 19'h00000);
        end else if (count != 19'h00000) begin
            count  <= count - 19'h00001;
            done_o <= (count == 19'h00001);
        end else begin
            done_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: logic/edc_ctrl.v
// Controller driving an EXTENDED_DATA_OUT_PAGE page-mode 1M x 4 DRAM through its pins
// Behaviour
// - Cell address splits into 10-bit row then 10-bit column on shared pins
// - Cycle starts on row strobe low, ends with both strobes high
// - Row strobe held for minimum active time; precharge respected before next cycle
// - Read begins on later of column strobe or output gate with write high
// - Write begins on later of column strobe or write strobe
// - Write data driven before later of column or write strobe falls
// - Issue 1024 refreshes every 16 ms across all rows
// - Wait 200 us after power-up, then eight row strobe cycles
// - Row strobe held high during power-on
// - Repeat eight-cycle wake-up when refresh interval was exceeded
`timescale 1ns/1ps
`default_nettype none
`include "edc_regs.vh"
module edc_ctrl (
    input  wire        ref_clk_i,
    input  wire        rst_n_i,
    input  wire        req_i,
    input  wire        req_write_i,
    input  wire [19:0] req_addr_i,
    input  wire [3:0]  req_wdata_i,
    output reg         req_ready_o,
    output reg         rd_valid_o,
    output reg  [3:0]  rd_data_o,
    output reg         init_done_o,
    output reg  [9:0]  mux_address_pins_o,
    output reg         ras_n_o,
    output reg         cas_n_o,
    output reg         we_n_o,
    output reg         oe_n_o,
    output reg  [3:0]  data_pins_o,
    output reg         data_pins_oe_o,
    input  wire [3:0]  data_pins_i
);
    localparam [3:0] ST_PWRUP = 4'h0;
    localparam [3:0] ST_WAKE  = 4'h1;
    localparam [3:0] ST_IDLE  = 4'h2;
    localparam [3:0] ST_ROW   = 4'h3;
    localparam [3:0] ST_COL   = 4'h4;
    localparam [3:0] ST_DATA  = 4'h5;
    localparam [3:0] ST_PAGE  = 4'h6;
    localparam [3:0] ST_PRE   = 4'h7;
    localparam [3:0] ST_CBR1  = 4'h8;
    localparam [3:0] ST_CBR2  = 4'h9;
    localparam [3:0] ST_CBR3  = 4'hA;

    reg  [3:0]  state;
    reg  [3:0]  wake_cnt;
    reg  [9:0]  open_row;
    reg  [19:0] ref_tick;
    reg  [10:0] ref_owed;
    reg         cur_write;
    reg         tm_load;
    reg  [18:0] tm_value;
    wire        tm_done;

    edc_timer u_timer (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .load_i    (tm_load),
        .value_i   (tm_value),
        .done_o    (tm_done)
    );

    function [18:0] cyc19;
        input integer n;
        begin
            cyc19 = n[18:0];
        end
    endfunction

    wire ref_due = (ref_owed != 11'h000);
    wire ref_tick_hit = (ref_tick == (`EDC_REF_INT_CYC - 1));
    // Each refresh is paid off once, on the cycle its row strobe falls
    wire ref_done = (state == ST_CBR2);

    // Refresh bookkeeping: one refresh owed per interval
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_tick <= 20'h00000;
            ref_owed <= 11'h000;
        end else begin
            ref_tick <= ref_tick_hit ? 20'h00000 : ref_tick + 20'h00001;
            if (ref_tick_hit && !ref_done)
                ref_owed <= ref_owed + 11'h001;
            else if (!ref_tick_hit && ref_done && ref_due)
                ref_owed <= ref_owed - 11'h001;
        end
    end

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state              <= ST_PWRUP;
            wake_cnt           <= 4'h0;
            open_row           <= 10'h000;
            cur_write          <= 1'b0;
            tm_load            <= 1'b1;
            tm_value           <= cyc19(`EDC_PWRUP_CYC);
            req_ready_o        <= 1'b0;
            rd_valid_o         <= 1'b0;
            rd_data_o          <= 4'h0;
            init_done_o        <= 1'b0;
            mux_address_pins_o <= 10'h000;
            ras_n_o            <= 1'b1;
            cas_n_o            <= 1'b1;
            we_n_o             <= 1'b1;
            oe_n_o             <= 1'b1;
            data_pins_o        <= 4'h0;
            data_pins_oe_o     <= 1'b0;
        end else begin
            tm_load     <= 1'b0;
            rd_valid_o  <= 1'b0;
            req_ready_o <= 1'b0;
            case (state)
            ST_PWRUP: begin
                if (tm_done && !tm_load) begin
                    state    <= ST_CBR1;
                    wake_cnt <= 4'h0;
                end
            end
            ST_WAKE: begin
                wake_cnt <= wake_cnt + 4'h1;
                if (wake_cnt == (`EDC_WAKE_CYCLES - 1)) begin
                    init_done_o <= 1'b1;
                    state       <= ST_IDLE;
                end else begin
                    state <= ST_CBR1;
                end
            end
            ST_IDLE: begin
                if (ref_owed > 11'h400) begin
                    init_done_o <= 1'b0;
                    wake_cnt    <= 4'h0;
                    state       <= ST_CBR1;
                end else if (ref_due) begin
                    state <= ST_CBR1;
                end else if (req_i) begin
                    cur_write          <= req_write_i;
                    mux_address_pins_o <= req_addr_i[19:10];
                    open_row           <= req_addr_i[19:10];
                    state              <= ST_ROW;
                end else begin
                    req_ready_o <= 1'b1;
                end
            end
            ST_ROW: begin
                ras_n_o  <= 1'b0;
                tm_load  <= 1'b1;
                tm_value <= cyc19(`EDC_RAS_CYC);
                state    <= ST_COL;
            end
            ST_COL: begin
                mux_address_pins_o <= req_addr_i[9:0];
                if (cur_write) begin
                    data_pins_o    <= req_wdata_i;
                    data_pins_oe_o <= 1'b1;
                    we_n_o         <= 1'b0;
                    oe_n_o         <= 1'b1;
                end else begin
                    data_pins_oe_o <= 1'b0;
                    we_n_o         <= 1'b1;
                    oe_n_o         <= 1'b0;
                end
                state <= ST_DATA;
            end
            ST_DATA: begin
                cas_n_o <= 1'b0;
                state   <= ST_PAGE;
            end
            ST_PAGE: begin
                // One clock after column strobe falls, all access times are met
                if (!cur_write) begin
                    rd_data_o  <= data_pins_i;
                    rd_valid_o <= 1'b1;
                end
                cas_n_o        <= 1'b1;
                we_n_o         <= 1'b1;
                data_pins_oe_o <= 1'b0;
                if (req_i && !ref_due && tm_done && req_addr_i[19:10] == open_row) begin
                    cur_write <= req_write_i;
                    state     <= ST_COL;
                end else if (tm_done) begin
                    state <= ST_PRE;
                end
            end
            ST_PRE: begin
                ras_n_o  <= 1'b1;
                oe_n_o   <= 1'b1;
                tm_load  <= 1'b1;
                tm_value <= cyc19(`EDC_RP_CYC);
                state    <= ST_CBR3;
            end
            ST_CBR1: begin
                if (tm_done && !tm_load) begin
                    cas_n_o        <= 1'b0;
                    oe_n_o         <= 1'b1;
                    we_n_o         <= 1'b1;
                    data_pins_oe_o <= 1'b0;
                    state          <= ST_CBR2;
                end
            end
            ST_CBR2: begin
                ras_n_o  <= 1'b0;
                tm_load  <= 1'b1;
                tm_value <= cyc19(`EDC_RAS_CYC);
                state    <= ST_CBR3;
            end
            ST_CBR3: begin
                if (!ras_n_o && tm_done && !tm_load) begin
                    ras_n_o  <= 1'b1;
                    cas_n_o  <= 1'b1;
                    tm_load  <= 1'b1;
                    tm_value <= cyc19(`EDC_RP_CYC);
                end else if (ras_n_o && tm_done && !tm_load) begin
                    state <= init_done_o ? ST_IDLE : ST_WAKE;
                end
            end
            default: state <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: sim/edc_ctrl_chk.sv
// Pin-level assertions for the EXTENDED_DATA_OUT_PAGE DRAM controller
`timescale 1ns/1ps
`default_nettype none
module edc_ctrl_chk (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ras_n_o,
    input wire logic cas_n_o,
    input wire logic we_n_o,
    input wire logic data_pins_oe_o,
    input wire logic rd_valid_o,
    input wire logic init_done_o
);
    int cyc;
    int gap;
    int nfall;
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cyc <= 0;
            gap <= 0;
            nfall <= 0;
        end else begin
            cyc <= (cyc < 5000) ? cyc + 1 : cyc;
            gap <= ras_n_o ? gap + 1 : 0;
            nfall <= ($fell(ras_n_o) && nfall < 16) ? nfall + 1 : nfall;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_cas_fall;
        $fell(cas_n_o) && !ras_n_o;
    endsequence
    a_reset_ras_high: assert property (disable iff (1'b0) !rst_n_i |-> ras_n_o && cas_n_o)
        else $error("row strobe low in reset");
    a_pause_quiet: assert property (cyc < 1999 |-> ras_n_o)
        else $error("row strobe during power-up pause");
    a_wake_count: assert property ($rose(init_done_o) |-> nfall >= 8)
        else $error("ready before eight wake cycles");
    a_precharge_gap: assert property ($rose(ras_n_o) |=> ras_n_o)
        else $error("precharge too short");
    a_cbr_quiet: assert property ($fell(ras_n_o) && !cas_n_o |-> !data_pins_oe_o)
        else $error("data driven in refresh");
    a_write_setup: assert property (s_cas_fall ##0 !we_n_o |-> $past(data_pins_oe_o))
        else $error("write data late");
    a_read_released: assert property (s_cas_fall ##0 we_n_o |-> !data_pins_oe_o)
        else $error("data driven in read");
    a_read_sample: assert property (rd_valid_o |-> !$past(cas_n_o))
        else $error("read data sampled early");
    a_refresh_gap: assert property (init_done_o |-> gap < 400)
        else $error("refresh gap too long");
endmodule
bind edc_ctrl edc_ctrl_chk i_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ras_n_o(ras_n_o),
    .cas_n_o(cas_n_o), .we_n_o(we_n_o), .data_pins_oe_o(data_pins_oe_o),
    .rd_valid_o(rd_valid_o), .init_done_o(init_done_o));
`default_nettype wire

// file: sim/edc_dram_model.sv
// Behavioural EXTENDED_DATA_OUT_PAGE page DRAM
`timescale 1ns/1ps
`default_nettype none
module edc_dram_model (
    input  wire logic       ras_n_i,
    input  wire logic       cas_n_i,
    input  wire logic       we_n_i,
    input  wire logic       oe_n_i,
    input  wire logic [9:0] addr_i,
    input  wire logic [3:0] dq_i,
    output logic      [3:0] dq_o,
    output logic            dq_oe_o
);
    logic [3:0] mem [0:1048575];
    logic [9:0] row = 10'h000;
    logic [9:0] cnt = 10'h000;
    logic [3:0] last = 4'h0;
    initial dq_oe_o = 1'b0;
    assign dq_o = dq_oe_o ? last : ~last;
    always @(negedge ras_n_i) begin
        if (cas_n_i) row = addr_i;
        else cnt = cnt + 10'h001;
    end
    always @(negedge cas_n_i or negedge oe_n_i) begin
        if (!ras_n_i && !cas_n_i && we_n_i && !oe_n_i) begin
            last = mem[{row, addr_i}];
            dq_oe_o <= #30 1'b1;
        end
    end
    always @(negedge cas_n_i or negedge we_n_i) begin
        if (!ras_n_i && !cas_n_i && !we_n_i) begin
            mem[{row, addr_i}] = dq_i;
            dq_oe_o = 1'b0;
        end
    end
    always @(posedge ras_n_i or posedge cas_n_i or posedge oe_n_i) begin
        if ((ras_n_i && cas_n_i) || oe_n_i) dq_oe_o = 1'b0;
    end
endmodule
`default_nettype wire

// file: sim/tb_edc_ctrl.sv
// Testbench for the EXTENDED_DATA_OUT_PAGE DRAM controller
`timescale 1ns/1ps
`default_nettype none
module tb_edc_ctrl;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i = 1'b1;
    logic        req_i = 1'b0;
    logic        req_write_i = 1'b0;
    logic [19:0] req_addr_i = 20'h00000;
    logic [3:0]  req_wdata_i = 4'h0;
    wire         ready, rd_valid, init_done, ras_n, cas_n, we_n, oe_n, d_oe, m_oe;
    wire  [9:0]  addr;
    wire  [3:0]  rd_data, d_out, m_out, dq;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          n_ras = 0;
    assign dq = d_oe ? d_out : m_out;
    initial forever #50 ref_clk_i = ~ref_clk_i;
    always @(negedge ras_n) n_ras++;
    always @(negedge ref_clk_i) if (d_oe === 1'b1) check("bus clash", m_oe, 0);
    edc_ctrl i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .init_done_o(init_done),
        .mux_address_pins_o(addr), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n),
        .oe_n_o(oe_n), .data_pins_o(d_out), .data_pins_oe_o(d_oe), .data_pins_i(dq));
    edc_dram_model i_mem (.ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .oe_n_i(oe_n),
        .addr_i(addr), .dq_i(dq), .dq_o(m_out), .dq_oe_o(m_oe));
    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic take(input logic wr, input logic [19:0] a, input logic [3:0] d);
        int k;
        k = 0;
        while (ready !== 1'b1 && k < 3000) begin
            @(negedge ref_clk_i);
            k++;
        end
        req_i = 1'b1;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        do begin
            @(negedge ref_clk_i);
            k++;
        end while (!(ras_n === 1'b0 && cas_n === 1'b1) && k < 3000);
        check("taken", k < 3000, 1);
    endtask
    task automatic access(input logic wr, input logic [19:0] a, input logic [3:0] d);
        int k;
        take(wr, a, d);
        req_i = 1'b0;
        k = 0;
        while (!wr && rd_valid !== 1'b1 && k < 10) begin
            @(negedge ref_clk_i);
            k++;
        end
        if (!wr) begin
            check("read data", rd_data, d);
            check("read latency", k, 3);
            check("model drives", m_oe, 1);
        end
    endtask
    task automatic t_page;
        int k;
        int n0;
        k = 0;
        while (!(cas_n === 1'b0 && ras_n === 1'b1) && k < 400) begin
            @(negedge ref_clk_i);
            k++;
        end
        take(1'b0, 20'h3FF00, 4'h0);
        n0 = n_ras;
        @(negedge ref_clk_i);
        req_write_i = 1'b1;
        req_addr_i = 20'h3FF05;
        req_wdata_i = 4'h6;
        while (rd_valid !== 1'b1 && k < 420) begin
            @(negedge ref_clk_i);
            k++;
        end
        check("page read", rd_data, 4'h8);
        check("data held", dq, 4'h8);
        @(negedge ref_clk_i);
        req_i = 1'b0;
        check("row held", n_ras - n0, 0);
        access(1'b0, 20'h3FF05, 4'h6);
    endtask
    task automatic t_init;
        int k;
        k = 0;
        while (init_done !== 1'b1 && k < 3000) begin @(negedge ref_clk_i); k++; end
        check("init done", init_done, 1);
        check("pause", k >= 2000, 1);
    endtask
    task automatic t_rdwr;
        logic [19:0] a [4] = '{20'h00000, 20'hFFFFF, 20'h3FF00, 20'h3FF01};
        for (int i = 0; i < 4; i++) access(1'b1, a[i], 4'hA - i[3:0]);
        for (int i = 0; i < 4; i++) access(1'b0, a[i], 4'hA - i[3:0]);
        access(1'b1, 20'h3FF02, 4'h5);
        access(1'b0, 20'h3FF02, 4'h5);
    endtask
    task automatic t_refresh;
        int n0;
        n0 = n_ras;
        repeat (500) @(negedge ref_clk_i);
        check("refresh count", n_ras - n0 >= 3, 1);
        access(1'b0, 20'hFFFFF, 4'h9);
    endtask
    task automatic t_reset;
        @(negedge ref_clk_i);
        rst_n_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        check("ras in reset", ras_n, 1);
        check("init in reset", init_done, 0);
        rst_n_i = 1'b1;
        t_init();
        access(1'b0, 20'h00000, 4'hA);
    endtask
    task automatic stop_test;
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        stop_test();
    end
    initial begin
        #10 rst_n_i = 1'b0;
        repeat (6) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        t_init();
        t_rdwr();
        t_page();
        t_refresh();
        t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
